// ==== asp_params.svh ====
// Timing figures, widths and derived cycle counts for the static memory host port
`ifndef ASP_PARAMS_SVH
`define ASP_PARAMS_SVH

// ==========================================================
// Geometry
`define ASP_ADDR_W      17
`define ASP_DATA_W      8
`define ASP_WORDS       131072

// ==========================================================
// Clock
`define ASP_CLK_PS      4000

// ==========================================================
// Times in ns as printed
`define ASP_T_WC_NS     30
`define ASP_T_WP_NS     26
`define ASP_T_AW_NS     28
`define ASP_T_AH_NS     3
`define ASP_T_RC_NS     40
`define ASP_T_OE_ACC_NS 10
`define ASP_T_HZ_NS     12

// ==========================================================
// Least times rounded up to whole cycles
`define ASP_CYC_UP(ns)  ((((ns) * 1000) + `ASP_CLK_PS - 1) / `ASP_CLK_PS)
`define ASP_WC_CYC      `ASP_CYC_UP(`ASP_T_WC_NS)
`define ASP_WP_CYC      `ASP_CYC_UP(`ASP_T_WP_NS)
`define ASP_AW_CYC      `ASP_CYC_UP(`ASP_T_AW_NS)
`define ASP_AH_CYC      `ASP_CYC_UP(`ASP_T_AH_NS)
`define ASP_RC_CYC      `ASP_CYC_UP(`ASP_T_RC_NS)
`define ASP_OE_CYC      `ASP_CYC_UP(`ASP_T_OE_ACC_NS)
`define ASP_HZ_CYC      `ASP_CYC_UP(`ASP_T_HZ_NS)

`endif

// ==== asp_pkg.sv ====
// Types shared by the static memory host port
package asp_pkg;
`include "asp_params.svh"

  typedef logic [`ASP_ADDR_W-1:0] asp_addr_t;
  typedef logic [`ASP_DATA_W-1:0] asp_byte_t;

  typedef enum logic [2:0] {
    ASP_RECOVER,
    ASP_IDLE,
    ASP_WR_PULSE,
    ASP_WR_HOLD,
    ASP_RD,
    ASP_TURN,
    ASP_RETAIN
  } asp_state_t;
endpackage

// ==== asp_timer.sv ====
// Phase timer: counts a loaded length down to zero
`timescale 1ns/1ps
module asp_timer #(
  parameter int          CW   = 8,
  parameter logic [7:0]  INIT = 8'h00
) (
  // Clock and reset
  input  wire logic          ref_clk,
  input  wire logic          nrst,
  // Control
  input  wire logic          load,
  input  wire logic [CW-1:0] load_val,
  // Status
  output logic               expired
);
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;

  generate
    if (CW < 2 || CW > 8) begin : g_bad_cw
      $error("asp_timer: CW must be 2 to 8");
    end
  endgenerate

  assign expired  = (cnt_reg == '0);
  assign cnt_next = load ? load_val : (expired ? cnt_reg : cnt_reg - 1'b1);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= INIT[CW-1:0];
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule // asp_timer

// ==== asp_sram_host.sv ====
// Host controller driving an asynchronous 128K x 8 static memory through its pins
// Operation
// RQ1 - Memory is 131072 bytes, 17-bit address
// RQ2 - Low first select high deselects device
// RQ3 - High second select low deselects device
// RQ4 - Selects active, strobe high, enable low reads
// RQ5 - Selects active, strobe low writes data
// RQ6 - Strobe and enable high float lines
// RQ7 - Write happens only while all three active
// RQ8 - Write starts all active, ends any inactive
// RQ9 - Host holds data around terminating edge
// RQ10 - Output enable high keeps lines floating during write
// RQ11 - Address 28 ns, pulse 26, cycle 30
// RQ12 - Read data valid 10 ns after enable
// RQ13 - Host keeps device deselected during retention
// RQ14 - Host keeps output enable high in retention
// RQ15 - Controls inactive while supply moves
// RQ16 - Wait one read cycle after power up
// RQ17 - Retention entry from deselect needs no wait
// RQ18 - Only completed writes alter stored words
`timescale 1ns/1ps
`include "asp_params.svh"
module asp_sram_host #(
  parameter int CW = 8
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  // Request side
  input  wire logic              req_valid,
  input  wire logic              req_write,
  input  wire asp_pkg::asp_addr_t req_addr,
  input  wire asp_pkg::asp_byte_t req_wdata,
  output logic                   req_ready,
  // Answer side
  output logic                   rsp_valid,
  output asp_pkg::asp_byte_t     rsp_rdata,
  // Retention control
  input  wire logic              retain_req,
  output logic                   retained,
  // Memory pins
  output asp_pkg::asp_addr_t     word_index_lines,
  output logic                   select_one_n,
  output logic                   select_two_hi,
  output logic                   write_n,
  output logic                   out_enable_n,
  output asp_pkg::asp_byte_t     byte_lines_o,
  output logic                   byte_lines_oe,
  input  wire asp_pkg::asp_byte_t byte_lines_i
);
  import asp_pkg::*;

  // ==========================================================
  // Phase lengths
  localparam int WP_LEN   = `ASP_WP_CYC;
  localparam int REST_LEN = `ASP_WC_CYC - `ASP_WP_CYC;
  localparam int RD_LEN   = (`ASP_RC_CYC > `ASP_OE_CYC) ? `ASP_RC_CYC : `ASP_OE_CYC;
  localparam int HZ_LEN   = `ASP_HZ_CYC;
  localparam logic [7:0] RECOVER_INIT = 8'(`ASP_RC_CYC - 1);

  generate
    if (REST_LEN < `ASP_AH_CYC || WP_LEN < `ASP_AW_CYC) begin : g_bad_write
      $error("asp_sram_host: write phases cannot meet address timing");
    end
    if (RD_LEN > (1 << CW) || CW > 8) begin : g_bad_cw
      $error("asp_sram_host: CW cannot hold the phase lengths");
    end
    if (WP_LEN > (1 << CW) || HZ_LEN > (1 << CW) || HZ_LEN < 1) begin : g_bad_phase
      $error("asp_sram_host: write or turnaround phase does not fit the timer");
    end
  endgenerate

  // ==========================================================
  // State
  asp_state_t state_reg;
  asp_state_t state_next;
  logic       expired;
  logic       take;
  logic       sel_act;
  logic       tmr_load;
  logic [CW-1:0] tmr_val;
  // Decoded phase of the coming cycle
  logic       to_pulse;
  logic       to_hold;
  logic       to_read;
  logic       to_idle;
  logic       to_retain;
  logic       read_done;

  asp_addr_t addr_reg;
  asp_byte_t wdata_reg;
  asp_byte_t rdata_reg;
  logic      sel_one_n_reg;
  logic      sel_two_reg;
  logic      write_n_reg;
  logic      oe_n_reg;
  logic      drive_reg;
  logic      ready_reg;
  logic      rsp_reg;
  logic      retained_reg;

  assign take = (state_reg == ASP_IDLE) && req_valid && ready_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ASP_RECOVER:  if (expired) state_next = ASP_IDLE;                        // RQ16
      ASP_IDLE: begin
        // A taken request wins over retention
        if (take) begin
          state_next = req_write ? ASP_WR_PULSE : ASP_RD;
        end else if (retain_req) begin
          state_next = ASP_RETAIN;                                             // RQ17
        end
      end
      ASP_WR_PULSE: if (expired) state_next = (REST_LEN > 0) ? ASP_WR_HOLD : ASP_IDLE; // RQ11
      ASP_WR_HOLD:  if (expired) state_next = ASP_IDLE;                        // RQ11
      ASP_RD:       if (expired) state_next = ASP_TURN;                        // RQ12
      // Turnaround lets the device float its lines first
      ASP_TURN:     if (expired) state_next = ASP_IDLE;
      // Supply may have dropped, so recovery is repeated on exit
      ASP_RETAIN:   if (!retain_req) state_next = ASP_RECOVER;                 // RQ16
      default:      state_next = ASP_RECOVER;
    endcase
  end

  // ==========================================================
  // Phase timer
  assign tmr_load = (state_next != state_reg);
  assign tmr_val  = (state_next == ASP_WR_PULSE) ? CW'(WP_LEN - 1) :
                    (state_next == ASP_WR_HOLD)  ? CW'(REST_LEN - 1) :
                    (state_next == ASP_RD)       ? CW'(RD_LEN - 1) :
                    (state_next == ASP_TURN)     ? CW'(HZ_LEN - 1) :
                    (state_next == ASP_RECOVER)  ? CW'(`ASP_RC_CYC - 1) : '0;

  // Preloaded with the recovery count, so release starts counting at once
  asp_timer #(
    .CW   (CW),
    .INIT (RECOVER_INIT)
  ) u_timer (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .load     (tmr_load),
    .load_val (tmr_val),
    .expired  (expired)
  );

  // ==========================================================
  // Decode of the coming phase
  assign to_pulse  = (state_next == ASP_WR_PULSE);
  assign to_hold   = (state_next == ASP_WR_HOLD);
  assign to_read   = (state_next == ASP_RD);
  assign to_idle   = (state_next == ASP_IDLE);
  assign to_retain = (state_next == ASP_RETAIN);
  assign read_done = (state_reg == ASP_RD) && expired;
  // Selects wrap the strobe, so the rising strobe alone ends each write
  assign sel_act   = to_pulse || to_hold || to_read;

  // ==========================================================
  // Pin next values, all registered

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg     <= ASP_RECOVER;
      sel_one_n_reg <= 1'b1;                                                   // RQ15
      sel_two_reg   <= 1'b0;                                                   // RQ15
      write_n_reg   <= 1'b1;
      oe_n_reg      <= 1'b1;                                                   // RQ15
      drive_reg     <= 1'b0;
    end else begin
      state_reg     <= state_next;
      sel_one_n_reg <= !sel_act;                                               // RQ2
      sel_two_reg   <= sel_act;                                                // RQ3 RQ13
      write_n_reg   <= !to_pulse;                                              // RQ5 RQ7 RQ8
      oe_n_reg      <= !to_read;                                               // RQ4 RQ10 RQ14
      drive_reg     <= to_pulse || to_hold;                                    // RQ9
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      addr_reg  <= '0;
      wdata_reg <= '0;
    end else if (take) begin
      // Held through pulse and hold so the rising strobe sees stable data
      addr_reg  <= req_addr;                                                   // RQ1 RQ9
      wdata_reg <= req_wdata;                                                  // RQ18
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_reg    <= '0;
      rsp_reg      <= 1'b0;
      ready_reg    <= 1'b0;
      retained_reg <= 1'b0;
    end else begin
      rsp_reg      <= read_done;                                               // RQ12
      if (read_done) begin
        rdata_reg  <= byte_lines_i;                                            // RQ4
      end
      // Ready only while idle, so at most one request is outstanding
      ready_reg    <= to_idle && !take;
      retained_reg <= to_retain;                                               // RQ13
    end
  end

  // ==========================================================
  // Outputs
  // Every pin comes from a register, so no decode glitch can open a write
  assign word_index_lines = addr_reg;
  assign select_one_n     = sel_one_n_reg;
  assign select_two_hi    = sel_two_reg;
  assign write_n          = write_n_reg;
  assign out_enable_n     = oe_n_reg;
  assign byte_lines_o     = wdata_reg;
  assign byte_lines_oe    = drive_reg;                                         // RQ6
  assign req_ready        = ready_reg;
  assign rsp_valid        = rsp_reg;
  assign rsp_rdata        = rdata_reg;
  assign retained         = retained_reg;
endmodule // asp_sram_host

// ==== asp_sram_model.sv ====
// Behavioural 128K x 8 asynchronous static memory on the host's pins
`timescale 1ns/1ps
module asp_sram_model #(
  parameter logic [7:0] DEF = 8'hA5
) (
  // Host pins
  input  wire asp_pkg::asp_addr_t word_index_lines,
  input  wire logic               select_one_n,
  input  wire logic               select_two_hi,
  input  wire logic               write_n,
  input  wire logic               out_enable_n,
  input  wire asp_pkg::asp_byte_t byte_lines_o,
  input  wire logic               byte_lines_oe,
  // Resolved data wire
  output asp_pkg::asp_byte_t      bus_level
);
  import asp_pkg::*;
  // ==========================================
  // Array and decode
  asp_byte_t mem [asp_addr_t];
  asp_byte_t wbuf;
  asp_byte_t last = 8'h00;
  asp_addr_t wadr;
  bit        wgot = 1'b0;
  logic      sel, wwin, rd;
  assign sel  = !select_one_n && select_two_hi;
  assign wwin = sel && !write_n;
  assign rd   = sel && write_n && !out_enable_n;
  // Track data up to the edge that closes the window
  always @* if (wwin) begin
    wbuf = bus_level;
    wadr = word_index_lines;
    wgot = 1'b1;
  end
  // Power-up settling of the pins is no window and stores nothing
  always @(negedge wwin) if (wgot) mem[wadr] = wbuf;
  always @* if (rd) last = mem.exists(word_index_lines) ? mem[word_index_lines] : DEF;
  // Floating lines show the inverse, never a held value
  assign bus_level = byte_lines_oe ? byte_lines_o : (rd ? last : ~last);
endmodule // asp_sram_model

// ==== asp_sram_host_sva.sv ====
// Checker on the host port pins and handshakes
`timescale 1ns/1ps
module asp_sram_host_sva (
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               nrst,
  // Handshake
  input  wire logic               req_valid,
  input  wire logic               req_write,
  input  wire logic               req_ready,
  input  wire logic               rsp_valid,
  input  wire logic               retain_req,
  input  wire logic               retained,
  // Memory pins
  input  wire asp_pkg::asp_addr_t word_index_lines,
  input  wire logic               select_one_n,
  input  wire logic               select_two_hi,
  input  wire logic               write_n,
  input  wire logic               out_enable_n,
  input  wire asp_pkg::asp_byte_t byte_lines_o,
  input  wire logic               byte_lines_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  chk_write_pulse: assert property ($fell(write_n) |-> !write_n [*7] ##1 write_n)
    else $error("write pulse length wrong");
  chk_write_steady: assert property (!write_n && !$fell(write_n) |->
    $stable(word_index_lines) && $stable(byte_lines_o))
    else $error("address or data moved in write");
  chk_write_pins: assert property (!write_n |->
    byte_lines_oe && out_enable_n && !select_one_n && select_two_hi)
    else $error("write pins wrong");
  chk_end_edge: assert property ($rose(write_n) |-> !select_one_n && byte_lines_oe
    ##1 select_one_n && !byte_lines_oe)
    else $error("write end sequence wrong");
  chk_read_pins: assert property (!out_enable_n |->
    write_n && !byte_lines_oe && !select_one_n && select_two_hi)
    else $error("read pins wrong");
  chk_read_answer: assert property (req_valid && req_ready && !req_write |->
    ##10 !out_enable_n ##1 rsp_valid && out_enable_n)
    else $error("read answer late");
  chk_retain_enter: assert property (retain_req && req_ready && !req_valid |->
    ##[1:2] retained)
    else $error("retention not entered");
  chk_retain_pins: assert property (retained |->
    select_one_n && !select_two_hi && out_enable_n && !req_ready)
    else $error("retention pins wrong");
  chk_recover_wait: assert property ($rose(nrst) |->
    (select_one_n && !req_ready) [*8] ##1 !req_ready [*2])
    else $error("recovery too short");
  chk_one_take: assert property (req_valid && req_ready |=> !req_ready)
    else $error("ready after take");
endmodule // asp_sram_host_sva
bind asp_sram_host asp_sram_host_sva i_asp_sram_host_sva (.ref_clk, .nrst, .req_valid,
  .req_write, .req_ready, .rsp_valid, .retain_req, .retained, .word_index_lines,
  .select_one_n, .select_two_hi, .write_n, .out_enable_n, .byte_lines_o, .byte_lines_oe);

// ==== test_asp_sram_host.sv ====
// Self-checking bench for the static memory host port
`timescale 1ns/1ps
module test_asp_sram_host;
  import asp_pkg::*;
  logic      ref_clk, nrst, req_valid, req_write, req_ready, rsp_valid, retain_req;
  logic      retained, select_one_n, select_two_hi, write_n, out_enable_n, byte_lines_oe;
  asp_addr_t req_addr, word_index_lines, a;
  asp_byte_t req_wdata, rsp_rdata, byte_lines_o, bus_level;
  int        err_total = 0;
  int        tests_run = 0;
  int        wait_n;
  asp_byte_t ref_mem [int];
  asp_byte_t exp_q [$];
  asp_sram_host i_asp_sram_host (.ref_clk, .nrst, .req_valid, .req_write, .req_addr,
    .req_wdata, .req_ready, .rsp_valid, .rsp_rdata, .retain_req, .retained,
    .word_index_lines, .select_one_n, .select_two_hi, .write_n, .out_enable_n,
    .byte_lines_o, .byte_lines_oe, .byte_lines_i(bus_level));
  asp_sram_model i_asp_sram_model (.word_index_lines, .select_one_n, .select_two_hi,
    .write_n, .out_enable_n, .byte_lines_o, .byte_lines_oe, .bus_level);
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // ==========================================
  // Compare and bus tasks
  task automatic chk_byte(input asp_byte_t g, input asp_byte_t e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %0t byte %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %0t flag %b expected %b", $time, g, e);
    end
  endtask
  task automatic wait_ready();
    wait_n = 0;
    do begin
      @(posedge ref_clk);
      wait_n++;
    end while (req_ready !== 1'b1 && wait_n < 100);
    if (req_ready !== 1'b1) begin
      err_total++;
      $display("ERROR %0t ready never came", $time);
    end
  endtask
  task automatic op(input logic w, input asp_addr_t ad, input asp_byte_t dt);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr  <= ad;
    req_wdata <= dt;
    wait_ready();
    req_valid <= 1'b0;
    if (w) ref_mem[ad] = dt;
    else exp_q.push_back(ref_mem.exists(ad) ? ref_mem[ad] : 8'hA5);
    @(posedge ref_clk);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge ref_clk) if (rsp_valid === 1'b1) begin
    chk_byte(rsp_rdata, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
  end
  initial begin
    #100us;
    err_total++;
    $display("ERROR %0t watchdog expired", $time);
    results();
  end
  // ==========================================
  // Main sequence
  initial begin
    nrst = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = '0;
    req_wdata = '0;
    retain_req = 1'b0;
    void'($urandom(32'h91052265));
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    wait_ready();
    chk_bit(wait_n > 10, 1'b1);
    $display("test recovery done");
    // Both ends of the address range, taken in turn, with reads mixed in at random
    for (int i = 0; i < 48; i++) begin
      a = asp_addr_t'($urandom_range(0, 3)) ^ (i % 2 ? 17'h1FFFF : 17'h00000);
      op(i < 8 || $urandom_range(0, 1), a, asp_byte_t'($urandom));
    end
    repeat (20) @(posedge ref_clk);
    chk_bit(exp_q.size() == 0, 1'b1);
    $display("test traffic done");
    retain_req <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk_bit(retained, 1'b1);
    chk_bit(select_one_n && !select_two_hi && out_enable_n, 1'b1);
    fork
      op(1'b1, 17'h00005, 8'h3C);
      begin
        repeat (6) @(posedge ref_clk);
        retain_req <= 1'b0;
      end
    join
    chk_bit(wait_n > 15, 1'b1);
    op(1'b0, 17'h00005, 8'h00);
    repeat (20) @(posedge ref_clk);
    chk_bit(exp_q.size() == 0, 1'b1);
    $display("test retention done");
    nrst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk_bit(select_one_n, 1'b1);
    nrst <= 1'b1;
    wait_ready();
    chk_bit(wait_n > 10, 1'b1);
    op(1'b0, 17'h00005, 8'h00);
    repeat (20) @(posedge ref_clk);
    chk_bit(exp_q.size() == 0, 1'b1);
    $display("test reset done");
    results();
  end
endmodule // test_asp_sram_host
